/* File: shared/tsce_pkg.sv */
/*
 Package for the test, shift and control execution unit: register offsets,
 status field positions, opcodes, sub-operation codes, shift kinds and
 cycle counts. It assumes a 24-bit word with bit 23 as the most significant bit.
*/
package tsce_pkg;
	localparam int TSCE_ADDR_W = 8;
	localparam logic [7:0] TSCE_OFF_CTRL = 8'h00;
	localparam logic [7:0] TSCE_OFF_INSTR = 8'h04;
	localparam logic [7:0] TSCE_OFF_OPND = 8'h08;
	localparam logic [7:0] TSCE_OFF_A = 8'h0c;
	localparam logic [7:0] TSCE_OFF_B = 8'h10;
	localparam logic [7:0] TSCE_OFF_X = 8'h14;
	localparam logic [7:0] TSCE_OFF_P = 8'h18;
	localparam logic [7:0] TSCE_OFF_STAT = 8'h1c;
	localparam logic [7:0] TSCE_OFF_REMOTE = 8'h20;
	localparam int TSCE_CTRL_RESTART = 0;
	localparam int TSCE_CTRL_CLR_ILL = 1;
	localparam int TSCE_ST_BUSY = 0;
	localparam int TSCE_ST_HALT = 1;
	localparam int TSCE_ST_OVF = 2;
	localparam int TSCE_ST_IEN = 3;
	localparam int TSCE_ST_REMOTE = 4;
	localparam int TSCE_ST_ILL = 5;
	localparam logic [13:0] TSCE_RST_P = 14'h0000;
	localparam logic [23:0] TSCE_RST_WORD = 24'h000000;
	localparam logic [5:0] TSCE_OP_HALT = 6'h00;
	localparam logic [5:0] TSCE_OP_NOP = 6'h10;
	localparam logic [5:0] TSCE_OP_EXU = 6'h13;
	localparam logic [5:0] TSCE_OP_EOM = 6'h02;
	localparam logic [5:0] TSCE_OP_SKS = 6'h20;
	localparam logic [5:0] TSCE_OP_SKD = 6'h3c;
	localparam logic [5:0] TSCE_OP_SHR = 6'h36;
	localparam logic [5:0] TSCE_OP_SHL = 6'h37;
	localparam logic [14:0] TSCE_AD_BP1 = 15'h2100;
	localparam logic [14:0] TSCE_AD_BP2 = 15'h2080;
	localparam logic [14:0] TSCE_AD_BP3 = 15'h2040;
	localparam logic [14:0] TSCE_AD_BP4 = 15'h2020;
	localparam logic [14:0] TSCE_AD_OVT = 15'h2001;
	localparam logic [14:0] TSCE_AD_IET = 15'h2004;
	localparam logic [14:0] TSCE_AD_IDT = 15'h2002;
	localparam logic [14:0] TSCE_AD_ROV = 15'h2001;
	localparam logic [14:0] TSCE_AD_REO = 15'h2008;
	localparam logic [14:0] TSCE_AD_EIR = 15'h2002;
	localparam logic [14:0] TSCE_AD_DIR = 15'h2004;
	localparam logic [14:0] TSCE_AD_AIR = 15'h2010;
	localparam logic [5:0] TSCE_SUB_ARS = 6'h00;
	localparam logic [5:0] TSCE_SUB_ROR = 6'h10;
	localparam logic [5:0] TSCE_SUB_LSR = 6'h14;
	localparam logic [5:0] TSCE_SUB_ASL = 6'h00;
	localparam logic [5:0] TSCE_SUB_ROL = 6'h10;
	localparam logic [5:0] TSCE_SUB_NRM = 6'h08;
	localparam logic [5:0] TSCE_SHIFT_MAX = 6'd48;
	localparam logic [5:0] TSCE_STEP_R = 6'd8;
	localparam logic [5:0] TSCE_STEP_L = 6'd12;
	localparam int TSCE_NORM_STEPS = 12;
	localparam logic [2:0] TSCE_LAT_SHORT = 3'd1;
	localparam logic [2:0] TSCE_LAT_MID = 3'd2;
	localparam logic [2:0] TSCE_LAT_LONG = 3'd3;
	typedef enum logic [1:0] {
		TSCE_IDLE = 2'b00,
		TSCE_EXEC = 2'b01,
		TSCE_HALTED = 2'b11
	} tsce_state_t;
	typedef enum logic [2:0] {
		TSCE_SH_NONE = 3'd0,
		TSCE_SH_ARS = 3'd1,
		TSCE_SH_ROR = 3'd2,
		TSCE_SH_LSR = 3'd3,
		TSCE_SH_ASL = 3'd4,
		TSCE_SH_ROL = 3'd5,
		TSCE_SH_NRM = 3'd6
	} tsce_shift_t;
endpackage

/* File: test/tsce_core_bench.sv */
/*
 Self-checking bench for the test, shift and control execution unit.
 It assumes the unit alone on one 100 MHz clock, driven over APB by this bench.
*/
`timescale 1ns/1ps
module tsce_core_bench
	import tsce_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] ext_signal = 8'h00;
	logic [3:0] bp_switch = 4'h0;
	logic halted;
	logic interrupt_enabled;
	logic [7:0] interrupt_armed;
	logic remote_fetch;
	logic [14:0] bpa [4] = '{TSCE_AD_BP1, TSCE_AD_BP2, TSCE_AD_BP3, TSCE_AD_BP4};
	int bad_count = 0;
	int n_tests = 0;

	tsce_core u_dut (
		.clk(clk),
		.rst_n(rst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ext_signal(ext_signal),
		.bp_switch(bp_switch),
		.halted(halted),
		.interrupt_enabled(interrupt_enabled),
		.interrupt_armed(interrupt_armed),
		.remote_fetch(remote_fetch)
	);

	always #5 clk = ~clk;

	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rdat, output logic err);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			bad_count++;
			close_out;
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk("write error", e, 1'b0);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		logic e;
		apb(1'b0, a, 32'h0, d, e);
		chk("read error", e, 1'b0);
	endtask

	task exec(input logic [5:0] op, input logic [14:0] ad, input logic [13:0] dp,
		input logic [2:0] cyc);
		logic [31:0] s;
		int i;
		wr(TSCE_OFF_P, 32'h100);
		wr(TSCE_OFF_INSTR, {11'h000, op, ad});
		for (i = 0; i < 20; i++) begin
			rd(TSCE_OFF_STAT, s);
			if (s[TSCE_ST_BUSY] === 1'b0) break;
		end
		if (i == 20) begin
			bad_count++;
			close_out;
		end
		chk("cycles", s[22:20], cyc);
		rd(TSCE_OFF_P, s);
		chk("P", s[13:0], 14'h0100 + dp);
	endtask

	task sh(input logic [5:0] op, input logic [5:0] sub, input logic [8:0] n,
		input logic [47:0] ab, input logic [47:0] exp, input logic [2:0] cyc);
		logic [31:0] s;
		logic [31:0] t;
		wr(TSCE_OFF_A, {8'h00, ab[47:24]});
		wr(TSCE_OFF_B, {8'h00, ab[23:0]});
		exec(op, {sub, n}, 14'h1, cyc);
		rd(TSCE_OFF_A, s);
		rd(TSCE_OFF_B, t);
		chk("AB", {s[23:0], t[23:0]}, exp);
	endtask

	task t_skd;
		logic [31:0] s;
		wr(TSCE_OFF_X, 32'h0);
		wr(TSCE_OFF_B, 32'h010);
		wr(TSCE_OFF_OPND, 32'h005);
		exec(TSCE_OP_SKD, 15'h0, 14'h1, 3'd2);
		rd(TSCE_OFF_X, s);
		chk("X diff", s[23:0], 24'h00000b);
		wr(TSCE_OFF_B, 32'h005);
		wr(TSCE_OFF_OPND, 32'h010);
		exec(TSCE_OP_SKD, 15'h0, 14'h2, 3'd3);
		rd(TSCE_OFF_X, s);
		chk("X diff", s[23:0], 24'h00000b);
		ext_signal <= 8'h04;
		repeat (4) @(posedge clk);
		exec(TSCE_OP_SKS, 15'h0002, 14'h1, 3'd2);
		exec(TSCE_OP_SKS, 15'h0003, 14'h2, 3'd3);
		$display("skip tests done");
	endtask

	task t_shift;
		logic [47:0] ab;
		logic [47:0] ab2;
		logic [31:0] s;
		ab = 48'h812345_6789ab;
		ab2 = 48'h000123_456789;
		sh(TSCE_OP_SHR, TSCE_SUB_ARS, 9'd4, ab, {{4{ab[47]}}, ab[47:4]}, 3'd2);
		sh(TSCE_OP_SHR, TSCE_SUB_ROR, 9'd20, ab, {ab[19:0], ab[47:20]}, 3'd4);
		sh(TSCE_OP_SHR, TSCE_SUB_LSR, 9'd48, ab, 48'h0, 3'd7);
		sh(TSCE_OP_SHL, TSCE_SUB_ASL, 9'd13, ab2, ab2 << 13, 3'd3);
		sh(TSCE_OP_SHL, TSCE_SUB_ROL, 9'd7, ab, {ab[40:0], ab[47:41]}, 3'd2);
		sh(TSCE_OP_SHL, TSCE_SUB_ROL, 9'd48, ab, ab, 3'd5);
		wr(TSCE_OFF_X, 32'h100);
		sh(TSCE_OP_SHL, TSCE_SUB_NRM, 9'd9, 48'h0c0000_000000, 48'h600000_000000, 3'd2);
		rd(TSCE_OFF_X, s);
		chk("X norm", s[23:0], 24'h0000fd);
		sh(TSCE_OP_SHL, TSCE_SUB_NRM, 9'd30, 48'h1, 48'h1 << 30, 3'd4);
		rd(TSCE_OFF_X, s);
		chk("X norm", s[23:0], 24'h0000df);
		$display("shift tests done");
	endtask

	task t_ctrl;
		logic [31:0] s;
		logic [3:0] sw;
		logic e;
		exec(TSCE_OP_EXU, 15'h0123, 14'h0, 3'd1);
		rd(TSCE_OFF_REMOTE, s);
		chk("remote addr", s[13:0], 14'h0123);
		chk("remote_fetch", remote_fetch, 1'b1);
		exec(TSCE_OP_NOP, 15'h0, 14'h1, 3'd1);
		chk("remote_fetch", remote_fetch, 1'b0);
		for (int p = 0; p < 2; p++) begin
			sw = p ? 4'b1010 : 4'b0101;
			bp_switch <= sw;
			repeat (4) @(posedge clk);
			for (int k = 0; k < 4; k++) begin
				exec(TSCE_OP_SKS, bpa[k], sw[k] ? 14'h1 : 14'h2, sw[k] ? 3'd1 : 3'd2);
			end
		end
		exec(TSCE_OP_HALT, 15'h0, 14'h1, 3'd1);
		chk("halted", halted, 1'b1);
		apb(1'b1, TSCE_OFF_INSTR, {11'h000, TSCE_OP_NOP, 15'h0}, s, e);
		chk("instr refused", e, 1'b1);
		wr(TSCE_OFF_CTRL, 32'h1);
		@(posedge clk);
		chk("halted", halted, 1'b0);
		exec(6'h01, 15'h0, 14'h1, 3'd1);
		rd(TSCE_OFF_STAT, s);
		chk("illegal", s[TSCE_ST_ILL], 1'b1);
		wr(TSCE_OFF_CTRL, 32'h2);
		rd(TSCE_OFF_STAT, s);
		chk("illegal", s[TSCE_ST_ILL], 1'b0);
		apb(1'b0, 8'h40, 32'h0, s, e);
		chk("unmapped refused", e, 1'b1);
		apb(1'b1, TSCE_OFF_STAT, 32'h0, s, e);
		chk("status write refused", e, 1'b1);
		$display("control tests done");
	endtask

	task t_ovf_int;
		logic [31:0] s;
		wr(TSCE_OFF_X, 32'h200);
		exec(TSCE_OP_EOM, TSCE_AD_REO, 14'h1, 3'd1);
		rd(TSCE_OFF_STAT, s);
		chk("overflow", s[TSCE_ST_OVF], 1'b1);
		wr(TSCE_OFF_X, 32'h300);
		exec(TSCE_OP_EOM, TSCE_AD_REO, 14'h1, 3'd1);
		rd(TSCE_OFF_STAT, s);
		chk("overflow", s[TSCE_ST_OVF], 1'b1);
		exec(TSCE_OP_SKS, TSCE_AD_OVT, 14'h1, 3'd1);
		rd(TSCE_OFF_STAT, s);
		chk("overflow", s[TSCE_ST_OVF], 1'b0);
		exec(TSCE_OP_SKS, TSCE_AD_OVT, 14'h2, 3'd2);
		wr(TSCE_OFF_X, 32'h100);
		exec(TSCE_OP_EOM, TSCE_AD_REO, 14'h1, 3'd1);
		exec(TSCE_OP_EOM, TSCE_AD_ROV, 14'h1, 3'd1);
		rd(TSCE_OFF_STAT, s);
		chk("overflow", s[TSCE_ST_OVF], 1'b0);
		wr(TSCE_OFF_X, 32'h0);
		exec(TSCE_OP_EOM, TSCE_AD_REO, 14'h1, 3'd1);
		rd(TSCE_OFF_STAT, s);
		chk("overflow", s[TSCE_ST_OVF], 1'b0);
		exec(TSCE_OP_EOM, TSCE_AD_EIR, 14'h1, 3'd1);
		chk("int enabled", interrupt_enabled, 1'b1);
		exec(TSCE_OP_SKS, TSCE_AD_IET, 14'h2, 3'd2);
		exec(TSCE_OP_SKS, TSCE_AD_IDT, 14'h1, 3'd1);
		exec(TSCE_OP_EOM, TSCE_AD_DIR, 14'h1, 3'd1);
		chk("int enabled", interrupt_enabled, 1'b0);
		exec(TSCE_OP_SKS, TSCE_AD_IET, 14'h1, 3'd1);
		exec(TSCE_OP_SKS, TSCE_AD_IDT, 14'h2, 3'd2);
		wr(TSCE_OFF_OPND, 32'ha5);
		exec(TSCE_OP_EOM, TSCE_AD_AIR, 14'h1, 3'd1);
		chk("armed", interrupt_armed, 8'ha5);
		wr(TSCE_OFF_OPND, 32'h3c);
		exec(TSCE_OP_EOM, TSCE_AD_AIR, 14'h1, 3'd1);
		rd(TSCE_OFF_STAT, s);
		chk("armed", s[15:8], 8'h3c);
		$display("overflow and interrupt tests done");
	endtask

	initial begin
		logic [31:0] s;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(TSCE_OFF_STAT, s);
		chk("status reset", s, 32'h0);
		rd(TSCE_OFF_P, s);
		chk("P reset", s, 32'h0);
		t_skd;
		t_shift;
		t_ctrl;
		t_ovf_int;
		close_out;
	end
endmodule // tsce_core_bench

/* File: verilog/tsce_core.sv */
/*
 Execution unit for the skip, shift, control, overflow and interrupt group.
 It assumes an APB master on the same clock, asynchronous switch and signal
 pins, and software that fetches the remote word when asked to.
*/
`timescale 1ns/1ps
module tsce_core
	import tsce_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] ext_signal,
	input wire logic [3:0] bp_switch,
	output logic halted,
	output logic interrupt_enabled,
	output logic [7:0] interrupt_armed,
	output logic remote_fetch
);
	typedef struct packed {
		tsce_state_t state;
		logic [23:0] ir;
		logic [23:0] m;
		logic [23:0] a;
		logic [23:0] b;
		logic [23:0] x;
		logic [13:0] p;
		logic [2:0] cnt;
		logic [2:0] lat;
		logic [2:0] cyc;
		logic skip;
		logic [5:0] rem;
		logic ovf;
		logic int_en;
		logic [7:0] armed;
		logic remote_pend;
		logic [13:0] remote_addr;
		logic illegal;
		logic halted;
		logic done;
		logic [7:0] sig_s1;
		logic [7:0] sig_s2;
		logic [3:0] bp_s1;
		logic [3:0] bp_s2;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tsce_regs_t;

	tsce_regs_t s_q;
	tsce_regs_t s_d;

	function automatic tsce_shift_t shift_kind(input logic [23:0] w);
		tsce_shift_t k;
		k = TSCE_SH_NONE;
		if (w[20:15] == TSCE_OP_SHR) begin
			case (w[14:9])
				TSCE_SUB_ARS: k = TSCE_SH_ARS;
				TSCE_SUB_ROR: k = TSCE_SH_ROR;
				TSCE_SUB_LSR: k = TSCE_SH_LSR;
				default: k = TSCE_SH_NONE;
			endcase
		end else if (w[20:15] == TSCE_OP_SHL) begin
			case (w[14:9])
				TSCE_SUB_ASL: k = TSCE_SH_ASL;
				TSCE_SUB_ROL: k = TSCE_SH_ROL;
				TSCE_SUB_NRM: k = TSCE_SH_NRM;
				default: k = TSCE_SH_NONE;
			endcase
		end
		return k;
	endfunction

	function automatic logic [47:0] shift_ab(input logic [47:0] ab, input tsce_shift_t kind,
		input logic [5:0] k);
		logic [6:0] kk;
		logic [6:0] inv;
		logic [47:0] r;
		kk = {1'b0, k};
		inv = 7'd48 - kk;
		case (kind)
			TSCE_SH_ARS: r = 48'($signed(ab) >>> kk);
			TSCE_SH_ROR: r = (ab >> kk) | (ab << inv);
			TSCE_SH_LSR: r = ab >> kk;
			TSCE_SH_ASL: r = ab << kk;
			TSCE_SH_ROL: r = (ab << kk) | (ab >> inv);
			default: r = ab;
		endcase
		return r;
	endfunction

	function automatic logic [9:0] exp_diff(input logic [23:0] bv, input logic [23:0] mv);
		return {1'b0, bv[8:0]} - {1'b0, mv[8:0]};
	endfunction

	always_comb begin
		logic [5:0] op;
		logic [14:0] ad;
		tsce_shift_t kind;
		logic fin;
		logic skip;
		logic [2:0] lat;
		logic [47:0] ab;
		logic [23:0] xv;
		logic [5:0] rem;
		logic [5:0] step;
		logic [5:0] k;
		logic [9:0] diff;
		logic [31:0] rd;
		logic err;
		logic acc;
		op = s_q.ir[20:15];
		ad = s_q.ir[14:0];
		kind = shift_kind(s_q.ir);
		fin = 1'b0;
		skip = s_q.skip;
		lat = s_q.lat;
		ab = {s_q.a, s_q.b};
		xv = s_q.x;
		rem = s_q.rem;
		step = TSCE_STEP_R;
		k = 6'd0;
		diff = exp_diff(s_q.b, s_q.m);
		rd = 32'h00000000;
		err = 1'b0;
		acc = psel & penable & ~s_q.pready;
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.sig_s1 = ext_signal;
		s_d.sig_s2 = s_q.sig_s1;
		s_d.bp_s1 = bp_switch;
		s_d.bp_s2 = s_q.bp_s1;
		s_d.pready = acc;
		if (acc) begin
			case (paddr)
				TSCE_OFF_CTRL: rd = 32'h00000000;
				TSCE_OFF_INSTR: begin
					rd = {8'h00, s_q.ir};
					err = pwrite & (s_q.state != TSCE_IDLE);
				end
				TSCE_OFF_OPND: begin
					rd = {8'h00, s_q.m};
					err = pwrite & (s_q.state == TSCE_EXEC);
				end
				TSCE_OFF_A: begin
					rd = {8'h00, s_q.a};
					err = pwrite & (s_q.state == TSCE_EXEC);
				end
				TSCE_OFF_B: begin
					rd = {8'h00, s_q.b};
					err = pwrite & (s_q.state == TSCE_EXEC);
				end
				TSCE_OFF_X: begin
					rd = {8'h00, s_q.x};
					err = pwrite & (s_q.state == TSCE_EXEC);
				end
				TSCE_OFF_P: begin
					rd = {18'h00000, s_q.p};
					err = pwrite & (s_q.state == TSCE_EXEC);
				end
				TSCE_OFF_STAT: begin
					rd = {9'h000, s_q.cyc, s_q.bp_s2, s_q.armed, 2'b00, s_q.illegal,
						s_q.remote_pend, s_q.int_en, s_q.ovf, s_q.halted,
						s_q.state == TSCE_EXEC};
					err = pwrite;
				end
				TSCE_OFF_REMOTE: begin
					rd = {18'h00000, s_q.remote_addr};
					err = pwrite;
				end
				default: err = 1'b1;
			endcase
			s_d.prdata = rd;
			s_d.pslverr = err;
		end
		if (psel & penable & s_q.pready & pwrite & ~s_q.pslverr) begin
			case (paddr)
				TSCE_OFF_CTRL: begin
					if (pwdata[TSCE_CTRL_RESTART] && s_q.state == TSCE_HALTED) begin
						s_d.state = TSCE_IDLE;
						s_d.halted = 1'b0;
					end
					if (pwdata[TSCE_CTRL_CLR_ILL]) begin
						s_d.illegal = 1'b0;
					end
				end
				TSCE_OFF_INSTR: begin
					s_d.ir = pwdata[23:0];
					s_d.state = TSCE_EXEC;
					s_d.cnt = 3'd0;
					s_d.skip = 1'b0;
					s_d.remote_pend = 1'b0;
				end
				TSCE_OFF_OPND: s_d.m = pwdata[23:0];
				TSCE_OFF_A: s_d.a = pwdata[23:0];
				TSCE_OFF_B: s_d.b = pwdata[23:0];
				TSCE_OFF_X: s_d.x = pwdata[23:0];
				TSCE_OFF_P: s_d.p = pwdata[13:0];
				default: s_d.p = s_q.p;
			endcase
		end
		if (s_q.state == TSCE_EXEC) begin
			s_d.cnt = s_q.cnt + 3'd1;
			if (kind != TSCE_SH_NONE) begin
				if (s_q.cnt == 3'd0) begin
					s_d.rem = (s_q.ir[8:0] > {3'b000, TSCE_SHIFT_MAX}) ? TSCE_SHIFT_MAX : s_q.ir[5:0];
				end else begin
					if (kind == TSCE_SH_NRM) begin
						for (int i = 0; i < TSCE_NORM_STEPS; i++) begin
							if (rem != 6'd0 && ab[47] == ab[46]) begin
								ab = ab << 1;
								xv = xv - 24'h000001;
								rem = rem - 6'd1;
							end
						end
						fin = (rem == 6'd0) || (ab[47] != ab[46]);
					end else begin
						if (kind == TSCE_SH_ASL || kind == TSCE_SH_ROL) begin
							step = TSCE_STEP_L;
						end
						k = (rem < step) ? rem : step;
						ab = shift_ab(ab, kind, k);
						rem = rem - k;
						fin = (rem == 6'd0);
					end
					s_d.a = ab[47:24];
					s_d.b = ab[23:0];
					s_d.x = xv;
					s_d.rem = rem;
				end
			end else if (s_q.cnt == 3'd0) begin
				skip = 1'b0;
				lat = TSCE_LAT_SHORT;
				case (op)
					TSCE_OP_SKD: begin
						skip = diff[9];
						lat = skip ? TSCE_LAT_LONG : TSCE_LAT_MID;
					end
					TSCE_OP_SKS: begin
						case (ad)
							TSCE_AD_BP1: skip = ~s_q.bp_s2[0];
							TSCE_AD_BP2: skip = ~s_q.bp_s2[1];
							TSCE_AD_BP3: skip = ~s_q.bp_s2[2];
							TSCE_AD_BP4: skip = ~s_q.bp_s2[3];
							TSCE_AD_OVT: skip = ~s_q.ovf;
							TSCE_AD_IET: skip = s_q.int_en;
							TSCE_AD_IDT: skip = ~s_q.int_en;
							default: skip = ~s_q.sig_s2[ad[2:0]];
						endcase
						if (ad[14:12] == 3'b010) begin
							lat = skip ? TSCE_LAT_MID : TSCE_LAT_SHORT;
						end else begin
							lat = skip ? TSCE_LAT_LONG : TSCE_LAT_MID;
						end
					end
					default: lat = TSCE_LAT_SHORT;
				endcase
				s_d.skip = skip;
				s_d.lat = lat;
				fin = (lat == TSCE_LAT_SHORT);
			end else begin
				fin = (s_q.cnt == s_q.lat - 3'd1);
			end
			if (fin) begin
				s_d.state = TSCE_IDLE;
				s_d.done = 1'b1;
				s_d.cyc = s_q.cnt + 3'd1;
				s_d.p = s_q.p + (skip ? 14'd2 : 14'd1);
				case (op)
					TSCE_OP_HALT: begin
						s_d.state = TSCE_HALTED;
						s_d.halted = 1'b1;
					end
					TSCE_OP_NOP: s_d.p = s_q.p + 14'd1;
					TSCE_OP_EXU: begin
						s_d.p = s_q.p;
						s_d.remote_pend = 1'b1;
						s_d.remote_addr = ad[13:0];
					end
					TSCE_OP_EOM: begin
						case (ad)
							TSCE_AD_ROV: s_d.ovf = 1'b0;
							TSCE_AD_REO: begin
								if (s_q.x[9] != s_q.x[8]) begin
									s_d.ovf = 1'b1;
								end
							end
							TSCE_AD_EIR: s_d.int_en = 1'b1;
							TSCE_AD_DIR: s_d.int_en = 1'b0;
							TSCE_AD_AIR: s_d.armed = s_q.m[7:0];
							default: s_d.illegal = 1'b1;
						endcase
					end
					TSCE_OP_SKS: begin
						if (ad == TSCE_AD_OVT) begin
							s_d.ovf = 1'b0;
						end
					end
					TSCE_OP_SKD: s_d.x[8:0] = diff[9] ? 9'(-diff) : diff[8:0];
					TSCE_OP_SHR: s_d.p = s_q.p + 14'd1;
					TSCE_OP_SHL: s_d.p = s_q.p + 14'd1;
					default: s_d.illegal = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.state <= TSCE_IDLE;
			s_q.p <= TSCE_RST_P;
			s_q.a <= TSCE_RST_WORD;
			s_q.b <= TSCE_RST_WORD;
			s_q.x <= TSCE_RST_WORD;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign halted = s_q.halted;
	assign interrupt_enabled = s_q.int_en;
	assign interrupt_armed = s_q.armed;
	assign remote_fetch = s_q.remote_pend;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_SKD_VALUE: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_SKD |->
		s_q.x[8:0] == ((s_q.b[8:0] >= s_q.m[8:0]) ? s_q.b[8:0] - s_q.m[8:0] : s_q.m[8:0] - s_q.b[8:0]))
		else $error("exponent difference magnitude wrong");
	AST_SKD_STEP: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_SKD |->
		s_q.p == $past(s_q.p) + ((s_q.b[8:0] < s_q.m[8:0]) ? 14'd2 : 14'd1))
		else $error("exponent difference skip step wrong");
	AST_SKS_TIME: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_SKS &&
		s_q.ir[14:12] != 3'b010 |-> (s_q.cyc == 3'd2 && s_q.p == $past(s_q.p) + 14'd1) ||
		(s_q.cyc == 3'd3 && s_q.p == $past(s_q.p) + 14'd2))
		else $error("signal skip timing or step wrong");
	AST_RIGHT_TIME: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_SHR |->
		s_q.cyc >= 3'd2 && s_q.cyc <= 3'd7)
		else $error("right shift cycle count out of range");
	AST_LEFT_TIME: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_SHL |->
		s_q.cyc >= 3'd2 && s_q.cyc <= 3'd5)
		else $error("left shift cycle count out of range");
	AST_NORM_STOP: assert property (s_q.done && shift_kind(s_q.ir) == TSCE_SH_NRM |->
		s_q.rem == 6'd0 || s_q.a[23] != s_q.a[22])
		else $error("normalize stopped early");
	AST_EXU_HOLD: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_EXU |->
		s_q.p == $past(s_q.p) && s_q.remote_pend && s_q.cyc == 3'd1)
		else $error("execute remote changed P or did not request");
	AST_BPT_TIME: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_SKS &&
		s_q.ir[14:12] == 3'b010 |-> s_q.cyc == (s_q.p - $past(s_q.p)))
		else $error("internal test timing does not match skip");
	AST_OVT_RESET: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_SKS &&
		s_q.ir[14:0] == TSCE_AD_OVT |-> !s_q.ovf && s_q.p == $past(s_q.p) + ($past(s_q.ovf) ? 14'd1 : 14'd2))
		else $error("overflow test wrong");
	AST_ROV_CLEAR: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_EOM &&
		s_q.ir[14:0] == TSCE_AD_ROV |-> !s_q.ovf && s_q.cyc == 3'd1)
		else $error("overflow clear failed");
	AST_REO_SET: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_EOM &&
		s_q.ir[14:0] == TSCE_AD_REO |-> s_q.ovf == ($past(s_q.ovf) | ($past(s_q.x[9]) != $past(s_q.x[8]))))
		else $error("exponent overflow record wrong");
	AST_IEN_SET: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_EOM &&
		s_q.ir[14:0] == TSCE_AD_EIR |-> s_q.int_en ##1 s_q.int_en || s_q.done)
		else $error("interrupt enable not set");
	AST_HALT_STOP: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_HALT |->
		s_q.halted && s_q.state == TSCE_HALTED)
		else $error("halt did not stop");
	AST_AIR_ARM: assert property (s_q.done && s_q.ir[20:15] == TSCE_OP_EOM &&
		s_q.ir[14:0] == TSCE_AD_AIR |-> s_q.armed == $past(s_q.m[7:0]))
		else $error("armed levels differ from operand");

	COV_SKS_SKIP: cover property (s_q.done && s_q.ir[20:15] == TSCE_OP_SKS && s_q.cyc == 3'd3);
	COV_NORM: cover property (s_q.done && shift_kind(s_q.ir) == TSCE_SH_NRM && s_q.cyc > 3'd2);
	COV_HALT: cover property (s_q.done && s_q.ir[20:15] == TSCE_OP_HALT);
	COV_EXU: cover property (s_q.done && s_q.ir[20:15] == TSCE_OP_EXU);
endmodule // tsce_core
